//--- logic/cvs_pkg.sv
// Shared constants for the converter sequencer with window compare.
// Assumes an 8-bit special function register port and a 10-bit SAR.
`default_nettype none

package cvs_pkg;

  // Special function register addresses
  localparam logic [7:0] ADDR_CTRL_ONE = 8'hB2; // converter_control_one
  localparam logic [7:0] ADDR_CTRL_TWO = 8'hB3; // Prescale and channel select
  localparam logic [7:0] ADDR_RES_HIGH = 8'hB4; // result_upper_eight
  localparam logic [7:0] ADDR_RES_LOW = 8'hB5; // Result bits 7..0
  localparam logic [7:0] ADDR_UPPER = 8'hB6; // window_upper_limit
  localparam logic [7:0] ADDR_LOWER = 8'hB7; // window_lower_limit

  // Reset values
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // converter_control_one bit positions
  localparam int BIT_BUSY = 7; // start_busy_flag
  localparam int BIT_EOC = 6; // Completion flag
  localparam int BIT_MODE = 5; // repeat_mode_select
  localparam int BIT_EXTEN = 4; // external_trigger_enable
  localparam int BIT_QUAL = 3; // match_gates_interrupt
  localparam int BIT_WCM = 2; // window_match_flag
  localparam int BIT_POWER = 1; // analog_power_on
  localparam int BIT_OUTSIDE = 0; // window_outside_select

  // Second control register field positions
  localparam int CHAN_LSB = 4; // channel_select low bit
  localparam int PRESCALE_LSB = 0; // clock_prescale_select low bit

  // Conversion timing in converter clocks
  localparam logic [3:0] SAMPLE_LAST = 4'h4; // Five sample clocks: 0..4
  localparam logic [3:0] APPROX_FIRST = 4'h5; // Ten approximation clocks
  localparam logic [3:0] APPROX_LAST = 4'hE; // 5..14
  localparam logic [3:0] CONV_LAST = 4'hF; // Sixteenth clock completes

  // Result width
  localparam int RES_BITS = 10;

  // Sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } cvs_state_e;

endpackage

`default_nettype wire

//--- logic/cvs_sar_if.sv
// Carrier between the sequencer and its approximation register.
// Assumes both ends share the sequencer clock.
`timescale 1ns/100ps
`default_nettype none

interface cvs_sar_if;
  import cvs_pkg::*;

  logic beginConv; // Start approximation with bit 9 on trial
  logic step; // End of one approximation clock
  logic keep; // DAC below input: trial bit stays
  logic [RES_BITS-1:0] code; // Present DAC code

  // Sequencer side
  modport ctl (output beginConv, output step, output keep, input code);
  // Register side
  modport sar (input beginConv, input step, input keep, output code);
endinterface

`default_nettype wire

//--- logic/cvs_sar.sv
// Successive approximation register, one bit per step, MSB first.
// Assumes step never arrives before beginConv in a conversion.
`timescale 1ns/100ps
`default_nettype none

module cvs_sar
  import cvs_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Sequencer link
  cvs_sar_if.sar bus
);

  logic [RES_BITS-1:0] code_q, code_d; // Code driving the DAC
  logic [RES_BITS-1:0] mask_q, mask_d; // One-hot bit now on trial
  localparam logic [RES_BITS-1:0] TOP_BIT = {1'b1, {(RES_BITS-1){1'b0}}};
  localparam logic [RES_BITS-1:0] NONE = '0;

  ////////////////////////////////////////////////////////////////////
  // Next code: drop a failed trial bit, put the next one on trial
  always_comb begin
    code_d = code_q;
    mask_d = mask_q;
    if (bus.beginConv) begin
      // Bit 9 goes on trial first
      code_d = TOP_BIT;
      mask_d = TOP_BIT;
    end else if (bus.step) begin
      // Bit kept only while the DAC sits below the input
      code_d = (bus.keep ? code_q : (code_q & ~mask_q)) | (mask_q >> 1);
      mask_d = mask_q >> 1;
    end
  end

  // Register only
  always_ff @(posedge clock) begin
    if (srst) begin
      code_q <= NONE;
      mask_q <= NONE;
    end else begin
      code_q <= code_d;
      mask_q <= mask_d;
    end
  end

  assign bus.code = code_q;

endmodule

`default_nettype wire

//--- logic/cvs_sequencer.sv
// Converter sequencer: start control, timing, window compare, interrupt.
// Assumes the core's register port and the analog comparator pin.
//
// Behaviour
// - Two 8-bit limits compared with result 9..2
// - Match = outside XOR upper-less XOR lower-less
// - Limits symmetric; same equation in either order
// - Outside select 1 outside, 0 inside
// - Match flag updated at every conversion end
// - Qualified: interrupt needs completion and match
// - Unqualified: interrupt whenever completion flag sets
// - Writing busy bit 0 to 1 starts
// - Busy holds through conversion, hardware clears
// - Enabled falling edge on pin starts conversion
// - Sixteen clocks: five sample, ten approximate
// - Completion flag set on the last clock
// - Continuous mode restarts next cycle after completion
// - Single shot converts once then stops
// - Leaving continuous mode finishes current conversion
// - Power bit cleared aborts and clears busy
// - Powered down after reset
// - Control register layout, resets to zero
// - Approximate bit 9 to 0, keep if below
// - Converter clock is machine clock over N+1
// - Three-bit channel select for next conversion
`timescale 1ns/100ps
`default_nettype none

module cvs_sequencer
  import cvs_pkg::*;
#(
  parameter int PRESCALE_BITS = 4, // Width of clock_prescale_select
  parameter int CHAN_BITS = 3 // Width of channel_select
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Special function register port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  // Interrupt
  input wire logic converterIrqEnable,
  output logic converterIrq,
  // Analog side
  output logic analogPowerOn,
  output logic sampleHold,
  output logic [CHAN_BITS-1:0] channelSelect,
  output logic [RES_BITS-1:0] dacCode,
  input wire logic compDacBelow,
  // External start pin
  input wire logic extStartPin
);

  ////////////////////////////////////////////////////////////////////
  // Elaboration checks: fields must fit the second control register
  if (PRESCALE_BITS != CHAN_LSB) begin : g_bad_prescale
    $error("Prescale width must fill the low field");
  end
  if (CHAN_BITS < 1 || CHAN_BITS + CHAN_LSB > 7) begin : g_bad_chan
    $error("Channel width must fit below bit 7");
  end

  ////////////////////////////////////////////////////////////////////
  // Declarations

  // Sequencer state
  cvs_state_e state_q, state_d;
  logic [3:0] cnt_q, cnt_d; // Converter clock within the conversion
  logic [PRESCALE_BITS-1:0] pre_q, pre_d; // Machine clocks within ACLK

  // converter_control_one fields
  logic busy_q, busy_d; // start_busy_flag
  logic eoc_q, eoc_d; // Completion flag, also the interrupt flag
  logic mode_q, mode_d; // repeat_mode_select
  logic exten_q, exten_d; // external_trigger_enable
  logic qual_q, qual_d; // match_gates_interrupt
  logic wcm_q, wcm_d; // window_match_flag
  logic power_q, power_d; // analog_power_on
  logic outside_q, outside_d; // window_outside_select

  // Other registers
  logic [PRESCALE_BITS-1:0] prescale_q, prescale_d; // clock_prescale_select
  logic [CHAN_BITS-1:0] chanSel_q, chanSel_d; // channel_select as written
  logic [CHAN_BITS-1:0] chanLat_q, chanLat_d; // Channel of this conversion
  logic [7:0] upper_q, upper_d; // window_upper_limit
  logic [7:0] lower_q, lower_d; // window_lower_limit
  logic [RES_BITS-1:0] result_q, result_d; // Last completed result

  // Registered outputs
  logic irq_q, irq_d;
  logic sample_q, sample_d;
  logic [7:0] rdData_q, rdData_d;

  // Pin synchronisers: first stage read only by the second
  logic extMeta_q, extSync_q, extPrev_q;
  logic compMeta_q, compSync_q;

  // Combinational helpers
  logic tick; // Last machine clock of one converter clock
  logic swStart; // Software start request
  logic extFall; // Qualified falling edge on the pin
  logic done; // Conversion completes this cycle
  logic match; // Window comparison of the new result
  logic [7:0] resUpper; // result_upper_eight of the new result
  logic ctrlOneWr, ctrlTwoWr, upperWr, lowerWr; // Write decode

  // Approximation register link
  cvs_sar_if sarBus ();

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detector
  always_ff @(posedge clock) begin
    if (srst) begin
      extMeta_q <= 1'b1;
      extSync_q <= 1'b1;
      extPrev_q <= 1'b1;
      compMeta_q <= 1'b0;
      compSync_q <= 1'b0;
    end else begin
      // Two flops before any logic looks at the pins
      extMeta_q <= extStartPin;
      extSync_q <= extMeta_q;
      extPrev_q <= extSync_q;
      compMeta_q <= compDacBelow;
      compSync_q <= compMeta_q;
    end
  end

  // One request per falling edge, only when enabled
  assign extFall = extPrev_q & ~extSync_q & exten_q;

  ////////////////////////////////////////////////////////////////////
  // Write decode: plain address compare, one register each
  always_comb begin
    ctrlOneWr = 1'b0;
    ctrlTwoWr = 1'b0;
    upperWr = 1'b0;
    lowerWr = 1'b0;
    if (sfrWrite && sfrAddr == ADDR_CTRL_ONE) begin
      ctrlOneWr = 1'b1;
    end else if (sfrWrite && sfrAddr == ADDR_CTRL_TWO) begin
      ctrlTwoWr = 1'b1;
    end else if (sfrWrite && sfrAddr == ADDR_UPPER) begin
      upperWr = 1'b1;
    end else if (sfrWrite && sfrAddr == ADDR_LOWER) begin
      lowerWr = 1'b1;
    end
  end

  // Only a 0 to 1 transition starts; a write while busy is no start
  assign swStart = ctrlOneWr & sfrWrData[BIT_BUSY] & ~busy_q;

  // Divider ends its period when the count reaches N
  assign tick = (pre_q == prescale_q);

  // Window compare on bits 9..2 of the fresh code
  assign resUpper = sarBus.code[RES_BITS-1 -: 8];
  // No ordering between limits is assumed
  assign match = outside_q ^ (upper_q < resUpper) ^ (lower_q < resUpper);

  // Completion on the tick of the sixteenth converter clock
  assign done = (state_q == ST_CONV) && tick && (cnt_q == CONV_LAST);

  ////////////////////////////////////////////////////////////////////
  // Sequencer and register next values
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    pre_d = pre_q;
    busy_d = busy_q;
    eoc_d = eoc_q;
    mode_d = mode_q;
    exten_d = exten_q;
    qual_d = qual_q;
    wcm_d = wcm_q;
    power_d = power_q;
    outside_d = outside_q;
    prescale_d = prescale_q;
    chanSel_d = chanSel_q;
    chanLat_d = chanLat_q;
    upper_d = upper_q;
    lower_d = lower_q;
    result_d = result_q;
    sarBus.beginConv = 1'b0;
    sarBus.step = 1'b0;
    sarBus.keep = compSync_q;

    // Software writes to the plain control bits
    if (ctrlOneWr) begin
      mode_d = sfrWrData[BIT_MODE];
      exten_d = sfrWrData[BIT_EXTEN];
      qual_d = sfrWrData[BIT_QUAL];
      power_d = sfrWrData[BIT_POWER];
      outside_d = sfrWrData[BIT_OUTSIDE];
      // Writing 0 clears the flag, writing 1 leaves it
      eoc_d = eoc_q & sfrWrData[BIT_EOC];
    end
    if (ctrlTwoWr) begin
      prescale_d = sfrWrData[PRESCALE_LSB +: PRESCALE_BITS];
      chanSel_d = sfrWrData[CHAN_LSB +: CHAN_BITS];
    end
    // Both limits software programmable
    if (upperWr) begin
      upper_d = sfrWrData;
    end
    if (lowerWr) begin
      lower_d = sfrWrData;
    end

    case (state_q)
      ST_IDLE: begin
        // Either source may start; needs the converter powered
        if ((swStart || extFall) && power_d) begin
          state_d = ST_CONV;
          busy_d = 1'b1;
          cnt_d = 4'h0;
          pre_d = '0;
          // Channel taken as the conversion begins
          chanLat_d = chanSel_d;
        end
      end
      ST_CONV: begin
        // Further starts are ignored here
        // Busy cannot be written to 0 while running
        pre_d = tick ? '0 : PRESCALE_BITS'(pre_q + 1'b1);
        if (tick) begin
          cnt_d = 4'(cnt_q + 4'h1);
          if (cnt_q == SAMPLE_LAST) begin
            // Sampling over, bit 9 on trial
            sarBus.beginConv = 1'b1;
          end else if (cnt_q >= APPROX_FIRST && cnt_q <= APPROX_LAST) begin
            // One bit resolved per converter clock
            sarBus.step = 1'b1;
          end
        end
        if (done) begin
          result_d = sarBus.code;
          // Match refreshed on every result, set or cleared
          wcm_d = match;
          // Mode as it stands now decides: a late clear still
          // lets this conversion finish, then the converter halts
          if (mode_q) begin
            // Back to sampling on the next cycle
            cnt_d = 4'h0;
            pre_d = '0;
            chanLat_d = chanSel_d;
          end else begin
            // Single shot, or continuous just left
            state_d = ST_IDLE;
            busy_d = 1'b0;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        busy_d = 1'b0;
      end
    endcase

    // Completion set wins over a software clear in the same cycle
    if (done) begin
      eoc_d = 1'b1;
    end

    // Power removal aborts whatever is running
    if (!power_d) begin
      state_d = ST_IDLE;
      busy_d = 1'b0;
      cnt_d = 4'h0;
      pre_d = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output next values
  always_comb begin
    // Interrupt condition stands while the flag is set
    // Qualified form also needs the window match
    irq_d = converterIrqEnable & eoc_d & (~qual_d | wcm_d);
    // Sample-hold tracks during the first five clocks
    sample_d = (state_d == ST_CONV) && (cnt_d <= SAMPLE_LAST);
    // Read mux; unmapped addresses read zero
    rdData_d = BYTE_RESET;
    if (sfrAddr == ADDR_CTRL_ONE) begin
      // Readable at any time
      rdData_d = {busy_q, eoc_q, mode_q, exten_q, qual_q, wcm_q, power_q, outside_q};
    end else if (sfrAddr == ADDR_CTRL_TWO) begin
      rdData_d[CHAN_LSB +: CHAN_BITS] = chanSel_q;
      rdData_d[PRESCALE_LSB +: PRESCALE_BITS] = prescale_q;
    end else if (sfrAddr == ADDR_RES_HIGH) begin
      rdData_d = result_q[RES_BITS-1 -: 8];
    end else if (sfrAddr == ADDR_RES_LOW) begin
      rdData_d = result_q[7:0];
    end else if (sfrAddr == ADDR_UPPER) begin
      rdData_d = upper_q;
    end else if (sfrAddr == ADDR_LOWER) begin
      rdData_d = lower_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register everything; reset leaves the converter powered down
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      pre_q <= '0;
      // Whole control register resets to zero
      {busy_q, eoc_q, mode_q, exten_q} <= CTRL_ONE_RESET[7:4];
      {qual_q, wcm_q, power_q, outside_q} <= CTRL_ONE_RESET[3:0];
      prescale_q <= '0;
      chanSel_q <= '0;
      chanLat_q <= '0;
      upper_q <= BYTE_RESET;
      lower_q <= BYTE_RESET;
      result_q <= '0;
      irq_q <= 1'b0;
      sample_q <= 1'b0;
      rdData_q <= BYTE_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pre_q <= pre_d;
      busy_q <= busy_d;
      eoc_q <= eoc_d;
      mode_q <= mode_d;
      exten_q <= exten_d;
      qual_q <= qual_d;
      wcm_q <= wcm_d;
      power_q <= power_d;
      outside_q <= outside_d;
      prescale_q <= prescale_d;
      chanSel_q <= chanSel_d;
      chanLat_q <= chanLat_d;
      upper_q <= upper_d;
      lower_q <= lower_d;
      result_q <= result_d;
      irq_q <= irq_d;
      sample_q <= sample_d;
      rdData_q <= rdData_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Approximation register
  cvs_sar u_sar (
    .clock(clock),
    .srst(srst),
    .bus(sarBus.sar)
  );

  // Outputs, each from a flop
  assign sfrRdData = rdData_q;
  assign converterIrq = irq_q;
  assign analogPowerOn = power_q;
  assign sampleHold = sample_q;
  assign channelSelect = chanLat_q;
  assign dacCode = sarBus.code;

endmodule

`default_nettype wire

//--- verification/cvs_seq_assertions.sv
// Port checker for the converter sequencer.
// Assumes one clock domain; bound onto every cvs_sequencer.
`timescale 1ns/100ps
`default_nettype none

module cvs_seq_assertions
  import cvs_pkg::*;
#(
  parameter int PRESCALE_BITS = 4,
  parameter int CHAN_BITS = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Register port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWrData,
  input wire logic [7:0] sfrRdData,
  // Interrupt
  input wire logic converterIrqEnable,
  input wire logic converterIrq,
  // Analog side and pin
  input wire logic analogPowerOn,
  input wire logic sampleHold,
  input wire logic [CHAN_BITS-1:0] channelSelect,
  input wire logic [RES_BITS-1:0] dacCode,
  input wire logic compDacBelow,
  input wire logic extStartPin
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////
  logic [3:0] prescQ; // Prescale as last written, mirrored here
  logic [7:0] holdCntQ; // Length of the running sample phase

  // Helper mirror; a prescale change mid-run would mislead it
  always_ff @(posedge clock) begin
    if (srst) begin
      prescQ <= 4'h0;
      holdCntQ <= 8'h00;
    end else begin
      if (sfrWrite && sfrAddr == ADDR_CTRL_TWO) prescQ <= sfrWrData[3:0];
      holdCntQ <= sampleHold ? holdCntQ + 8'h01 : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////
  a_power_on: assert property (sfrWrite && sfrAddr == ADDR_CTRL_ONE && sfrWrData[BIT_POWER]
    |=> analogPowerOn) else $error("power bit write not applied");
  a_abort_now: assert property (sfrWrite && sfrAddr == ADDR_CTRL_ONE && !sfrWrData[BIT_POWER]
    |=> !analogPowerOn && !sampleHold) else $error("power off did not abort");
  a_unpowered_idle: assert property (!analogPowerOn |-> !sampleHold)
    else $error("sampling while unpowered");
  a_sample_len: assert property ($fell(sampleHold) && analogPowerOn
    |-> holdCntQ == 8'd5 * ({4'h0, prescQ} + 8'h01)) else $error("sample phase length wrong");
  a_msb_trial: assert property ($fell(sampleHold) && analogPowerOn
    |-> dacCode == 10'h200) else $error("first trial code wrong");
  a_unmapped_zero: assert property ((sfrAddr < ADDR_CTRL_ONE || sfrAddr > ADDR_LOWER)
    |=> sfrRdData == 8'h00) else $error("unmapped read not zero");
  a_limit_readback: assert property (sfrWrite && sfrAddr == ADDR_UPPER ##1 sfrAddr == ADDR_UPPER
    |=> sfrRdData == $past(sfrWrData, 2)) else $error("upper limit readback wrong");
  a_irq_gated: assert property (!converterIrqEnable |=> !converterIrq)
    else $error("interrupt without enable");
  a_irq_clear: assert property (sfrWrite && sfrAddr == ADDR_CTRL_ONE && !sfrWrData[BIT_EOC]
    && !sampleHold |=> !converterIrq) else $error("interrupt not cleared");
  a_chan_stable: assert property (sampleHold [*2] |-> $stable(channelSelect))
    else $error("channel moved while sampling");
endmodule

bind cvs_sequencer cvs_seq_assertions #(.PRESCALE_BITS(PRESCALE_BITS), .CHAN_BITS(CHAN_BITS))
  i_cvs_seq_assertions (.clock(clock), .srst(srst), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
  .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .converterIrqEnable(converterIrqEnable),
  .converterIrq(converterIrq), .analogPowerOn(analogPowerOn), .sampleHold(sampleHold),
  .channelSelect(channelSelect), .dacCode(dacCode), .compDacBelow(compDacBelow),
  .extStartPin(extStartPin));

`default_nettype wire

//--- verification/cvs_analog_model.sv
// Sample-hold, DAC and comparator seen from the sequencer.
// Assumes the bench sets the input level before each start.
`timescale 1ns/100ps
`default_nettype none

module cvs_analog_model
  import cvs_pkg::*;
(
  // Clock
  input wire logic clock,
  // From the sequencer
  input wire logic analogPowerOn,
  input wire logic sampleHold,
  input wire logic [RES_BITS-1:0] dacCode,
  // From the bench
  input wire logic [RES_BITS-1:0] level,
  // To the sequencer
  output logic compDacBelow
);
  logic [RES_BITS-1:0] heldQ; // Voltage captured by sample-hold
  logic toggleQ = 1'b0; // Junk while unpowered, never a stale level

  // Track input only while sampling
  always_ff @(posedge clock) begin
    if (sampleHold) heldQ <= level;
    toggleQ <= !toggleQ;
  end

  // Input stands half a step above its code, so an equal DAC code is below
  assign compDacBelow = analogPowerOn ? (dacCode <= heldQ) : toggleQ;
endmodule

`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the converter sequencer.
// Assumes prescale 3 so the comparator settles within each step.
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import cvs_pkg::*;
;
  typedef struct packed {
    logic [9:0] vin;
    logic [7:0] hi;
    logic [7:0] lo;
    logic outs;
    logic qual;
    logic ien;
  } cvs_row_s;

  logic clock = 1'b0, srst = 1'b1, sfrWrite = 1'b0, ien = 1'b0, pin = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [9:0] level = 10'h000; // Analog input the model samples
  wire logic [7:0] rdData;
  wire logic irq, pwr, sh, below;
  wire logic [2:0] chan;
  wire logic [9:0] dac;
  int error_cnt = 0, compares = 0, cycles = 0;
  cvs_row_s rows [6];

  cvs_sequencer i_cvs_sequencer (.clock(clock), .srst(srst), .sfrAddr(addr),
    .sfrWrite(sfrWrite), .sfrWrData(wdata), .sfrRdData(rdData), .converterIrqEnable(ien),
    .converterIrq(irq), .analogPowerOn(pwr), .sampleHold(sh), .channelSelect(chan),
    .dacCode(dac), .compDacBelow(below), .extStartPin(pin));
  cvs_analog_model i_cvs_analog_model (.clock(clock), .analogPowerOn(pwr), .sampleHold(sh),
    .dacCode(dac), .level(level), .compDacBelow(below));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One write strobe, released after the sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) #1;
    addr = a;
    wdata = d;
    sfrWrite = 1'b1;
    @(posedge clock) #1;
    sfrWrite = 1'b0;
  endtask

  // Read data is registered one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock) #1;
    addr = a;
    @(posedge clock) #1;
    d = rdData;
  endtask

  // Poll busy with a bound so a stuck flag cannot hang the run
  task automatic waitIdle;
    logic [7:0] v;
    int n;
    v = 8'hFF;
    n = 0;
    while (v[BIT_BUSY] === 1'b1 && n < 200) begin
      rd(ADDR_CTRL_ONE, v);
      n++;
    end
    chk(8'(v[BIT_BUSY]), 8'h00);
  endtask

  initial forever #20 clock = ~clock;

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      summarize;
    end
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    logic m;
    cvs_row_s r;
    rows = '{'{10'h155, 8'h60, 8'h40, 1'b0, 1'b1, 1'b1}, '{10'h155, 8'h60, 8'h40, 1'b1, 1'b1, 1'b1},
      '{10'h3FF, 8'h60, 8'h40, 1'b1, 1'b1, 1'b1}, '{10'h000, 8'h40, 8'h60, 1'b0, 1'b0, 1'b1},
      '{10'h1A3, 8'h40, 8'h70, 1'b0, 1'b0, 1'b0}, '{10'h180, 8'h60, 8'h40, 1'b0, 1'b1, 1'b1}};
    repeat (20) @(posedge clock);
    #1 srst = 1'b0;
    // Reset values, unmapped and read-only places
    for (int i = 0; i < 6; i++) begin
      rd(ADDR_CTRL_ONE + 8'(i), v);
      chk(v, 8'h00);
    end
    chk(8'(pwr), 8'h00);
    rd(8'hB8, v);
    chk(v, 8'h00);
    wr(ADDR_RES_HIGH, 8'hAA);
    rd(ADDR_RES_HIGH, v);
    chk(v, 8'h00);
    wr(ADDR_CTRL_TWO, 8'h53);
    // Window compare table
    for (int i = 0; i < 6; i++) begin
      r = rows[i];
      level = r.vin;
      ien = r.ien;
      wr(ADDR_UPPER, r.hi);
      rd(ADDR_UPPER, v);
      chk(v, r.hi);
      wr(ADDR_LOWER, r.lo);
      wr(ADDR_CTRL_ONE, {4'h8, r.qual, 1'b0, 1'b1, r.outs});
      chk(8'(chan), 8'h05);
      waitIdle;
      m = r.outs ^ (r.hi < r.vin[9:2]) ^ (r.lo < r.vin[9:2]);
      rd(ADDR_RES_HIGH, v);
      chk(v, r.vin[9:2]);
      rd(ADDR_RES_LOW, v);
      chk(v, r.vin[7:0]);
      rd(ADDR_CTRL_ONE, v);
      chk(v, {4'h4, r.qual, m, 1'b1, r.outs});
      chk(8'(irq), 8'(r.ien & (!r.qual | m)));
      wr(ADDR_CTRL_ONE, {4'h0, r.qual, !m, 1'b1, r.outs});
      chk(8'(irq), 8'h00);
      rd(ADDR_CTRL_ONE, v);
      chk(v, {4'h0, r.qual, m, 1'b1, r.outs});
    end
    // Busy ignores a zero write, then power off aborts
    wr(ADDR_CTRL_ONE, 8'h82);
    wr(ADDR_CTRL_ONE, 8'h42);
    rd(ADDR_CTRL_ONE, v);
    chk(v & 8'hFB, 8'h82);
    wr(ADDR_CTRL_ONE, 8'h00);
    rd(ADDR_CTRL_ONE, v);
    chk(v & 8'hFB, 8'h00);
    // Pin edge ignored when disabled, honoured once when enabled
    wr(ADDR_CTRL_ONE, 8'h02);
    pin = 1'b0;
    repeat (6) @(posedge clock);
    rd(ADDR_CTRL_ONE, v);
    chk(v & 8'h80, 8'h00);
    pin = 1'b1;
    wr(ADDR_CTRL_ONE, 8'h12);
    pin = 1'b0;
    repeat (6) @(posedge clock);
    rd(ADDR_CTRL_ONE, v);
    chk(v & 8'h80, 8'h80);
    waitIdle;
    repeat (10) @(posedge clock);
    rd(ADDR_CTRL_ONE, v);
    chk(v & 8'hFB, 8'h52);
    pin = 1'b1;
    // Continuous mode, then back to single shot
    wr(ADDR_CTRL_ONE, 8'hA2);
    // New channel waits for the next restart, running one keeps its own
    wr(ADDR_CTRL_TWO, 8'h23);
    chk(8'(chan), 8'h05);
    for (int i = 0; i < 80; i++) begin
      rd(ADDR_CTRL_ONE, v);
      chk(v & 8'hA0, 8'hA0);
    end
    chk(v & 8'h40, 8'h40);
    chk(8'(chan), 8'h02);
    wr(ADDR_CTRL_ONE, 8'h42);
    waitIdle;
    repeat (80) @(posedge clock);
    rd(ADDR_CTRL_ONE, v);
    chk(v & 8'h80, 8'h00);
    summarize;
  end
endmodule

`default_nettype wire
